// ==== rtl/hsitd_top.sv ====
// Isochronous periodic transfer descriptor engine with APB register access.
//
// Operation
// - Stall sets halt and clears valid together.
// - Write transferred byte total, may be intermediate.
// - Buffer offset is internal word address.
// - Frame number from bits seven to three.
// - Split bit selects split or high-speed.
// - Token 00 OUT, 01 IN; category iso.
// - Address function with seven-bit device address.
// - Endpoint built from upper three plus lsb.
// - Repeat field bounds packets per execution.
// - Each packet limited to largest length, 1024.
// - Any whole-number packet length is accepted.
// - Clear valid when done or fatal error.
// - Send only in enabled microframes, then clear.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "hsitd_consts.svh"
module hsitd_top
    import hsitd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        sof_pin,
    input  wire logic [4:0]  bus_frame_num,
    input  wire logic [2:0]  bus_uframe,
    output logic             xfer_req,
    output logic [1:0]       xfer_token,
    output logic [6:0]       xfer_dev_addr,
    output logic [3:0]       xfer_endpoint,
    output logic             xfer_split,
    output logic [10:0]      xfer_max_len,
    output logic [15:0]      xfer_buf_addr,
    input  wire logic        xfer_done,
    input  wire logic [10:0] xfer_bytes,
    input  wire logic        xfer_stall
);
    hsitd_word_t           desc_q [0:4];
    hsitd_state_t          state_q;
    logic [`HSITD_NUM_EV-1:0] int_stat_q;
    logic [`HSITD_NUM_EV-1:0] int_en_q;
    logic [`HSITD_NUM_EV-1:0] ev;
    logic [2:0]            uframe_q;
    logic [1:0]            pkt_cnt_q;
    logic                  sof_lvl;
    logic                  sof_lvl_q;
    logic                  sof_pulse;
    logic                  wr_fire;
    logic [3:0]            wr_idx;
    logic [3:0]            rd_idx;
    logic                  valid;
    logic                  cat_ok;
    logic                  frame_hit;
    logic [10:0]           max_len;
    logic [1:0]            mult_eff;
    logic [14:0]           xcnt;
    logic [15:0]           xcnt_sum;
    logic [7:0]            umask;
    logic [7:0]            umask_left;
    logic                  hw_start;
    logic                  hw_fatal;
    logic                  hw_stall;
    logic                  hw_again;
    logic                  hw_finish;
    logic                  hw_retire;
    logic [14:0]           xcnt_next;
    logic [15:0]           buf_next;

    // Register index decode, shared by the read and write paths.
    function automatic logic [3:0] reg_index(input logic [11:0] a);
        logic [3:0] r;
        r = `HSITD_IDX_NONE;
        if (a == `HSITD_OFF_DW0) begin
            r = 4'h0;
        end else if (a == `HSITD_OFF_DW1) begin
            r = 4'h1;
        end else if (a == `HSITD_OFF_DW2) begin
            r = 4'h2;
        end else if (a == `HSITD_OFF_DW3) begin
            r = `HSITD_IDX_DW3;
        end else if (a == `HSITD_OFF_UMASK) begin
            r = `HSITD_IDX_UMASK;
        end else if (a == `HSITD_OFF_STATE) begin
            r = `HSITD_IDX_STATE;
        end else if (a == `HSITD_OFF_INT_STAT) begin
            r = `HSITD_IDX_INT_STAT;
        end else if (a == `HSITD_OFF_INT_CLR) begin
            r = `HSITD_IDX_INT_CLR;
        end else if (a == `HSITD_OFF_INT_EN) begin
            r = `HSITD_IDX_INT_EN;
        end
        return r;
    endfunction

    // Byte-lane merge of a write into a stored word.
    function automatic hsitd_word_t lane_merge(input hsitd_word_t old, input hsitd_word_t nw,
                                               input logic [3:0] strb);
        hsitd_word_t r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    hsitd_sync u_sof_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .async_in (sof_pin),
        .level_q  (sof_lvl)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sof_lvl_q <= 1'b0;
        end else if (ce) begin
            sof_lvl_q <= sof_lvl;
        end
    end

    assign sof_pulse  = sof_lvl & ~sof_lvl_q;
    assign wr_fire    = psel & penable & pwrite & pready;
    assign wr_idx     = reg_index(paddr);
    assign rd_idx     = reg_index(paddr);
    assign valid      = desc_q[0][`HSITD_DW0_VALID];
    assign cat_ok     = desc_q[1][`HSITD_DW1_EPCAT_LO +: 2] == `HSITD_EPCAT_ISO;
    assign frame_hit  = desc_q[2][`HSITD_DW2_FRAME_LO +: 5] == bus_frame_num;
    assign umask      = desc_q[4][7:0];
    assign xcnt       = desc_q[3][`HSITD_DW3_XCNT_LO +: 15];
    // Any length up to the ceiling is used as written; larger ones are clipped.
    assign max_len    = (desc_q[0][`HSITD_DW0_MAXPKT_LO +: 11] > `HSITD_MAX_PKT_CEIL) ?
                        `HSITD_MAX_PKT_CEIL : desc_q[0][`HSITD_DW0_MAXPKT_LO +: 11];
    // A repeat count of zero still moves one packet.
    assign mult_eff   = (desc_q[0][`HSITD_DW0_MULT_LO +: 2] == 2'h0) ?
                        2'h1 : desc_q[0][`HSITD_DW0_MULT_LO +: 2];
    assign xcnt_sum   = {1'b0, xcnt} + {5'h00, xfer_bytes};
    assign xcnt_next  = xcnt_sum[15] ? `HSITD_XCNT_FULL : xcnt_sum[14:0];
    // Packets are laid out back to back in eight-byte words of internal memory.
    assign buf_next   = desc_q[2][`HSITD_DW2_BUF_LO +: 16] + {4'h0, xcnt_sum[14:3]}
                        + {15'h0000, |xcnt_sum[2:0]};
    assign umask_left = umask & ~(8'h01 << uframe_q);

    always_comb begin
        hw_start  = 1'b0;
        hw_fatal  = 1'b0;
        hw_stall  = 1'b0;
        hw_again  = 1'b0;
        hw_finish = 1'b0;
        hw_retire = 1'b0;
        case (state_q)
            HSITD_ST_IDLE: begin
                if (sof_pulse && valid) begin
                    hw_fatal = !cat_ok;
                    hw_start = cat_ok && frame_hit && umask[bus_uframe];
                end
            end
            HSITD_ST_WAIT: begin
                if (xfer_done) begin
                    hw_stall  = xfer_stall;
                    hw_again  = !xfer_stall && (xfer_bytes == max_len)
                                && ({1'b0, pkt_cnt_q} + 3'h1 < {1'b0, mult_eff});
                    hw_finish = !xfer_stall && !hw_again;
                    hw_retire = hw_finish && (umask_left == 8'h00);
                end
            end
            default: begin
                hw_start = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= HSITD_ST_IDLE;
            uframe_q  <= 3'h0;
            pkt_cnt_q <= 2'h0;
        end else if (ce) begin
            case (state_q)
                HSITD_ST_IDLE: begin
                    if (hw_start) begin
                        state_q   <= HSITD_ST_WAIT;
                        uframe_q  <= bus_uframe;
                        pkt_cnt_q <= 2'h0;
                    end
                end
                HSITD_ST_WAIT: begin
                    if (hw_again) begin
                        pkt_cnt_q <= pkt_cnt_q + 2'h1;
                    end else if (xfer_done) begin
                        state_q <= HSITD_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= HSITD_ST_IDLE;
                end
            endcase
        end
    end

    // Transaction request toward the bus engine; fields other than xfer_buf_addr hold while the request stands, and xfer_buf_addr advances for each repeated packet.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_req      <= 1'b0;
            xfer_token    <= 2'h0;
            xfer_dev_addr <= 7'h00;
            xfer_endpoint <= 4'h0;
            xfer_split    <= 1'b0;
            xfer_max_len  <= 11'h000;
            xfer_buf_addr <= 16'h0000;
        end else if (ce) begin
            if (hw_start) begin
                xfer_req      <= 1'b1;
                xfer_token    <= desc_q[1][`HSITD_DW1_TOKEN_LO +: 2];
                xfer_dev_addr <= desc_q[1][`HSITD_DW1_DEV_LO +: 7];
                xfer_endpoint <= {desc_q[1][`HSITD_DW1_EP_UPPER_LO +: 3],
                                  desc_q[0][`HSITD_DW0_EP_LSB]};
                xfer_split    <= desc_q[1][`HSITD_DW1_SPLIT];
                xfer_max_len  <= max_len;
                xfer_buf_addr <= desc_q[2][`HSITD_DW2_BUF_LO +: 16] + {4'h0, xcnt[14:3]}
                                 + {15'h0000, |xcnt[2:0]};
            end else if (hw_again) begin
                xfer_buf_addr <= buf_next;
            end else if (state_q == HSITD_ST_WAIT && xfer_done) begin
                xfer_req <= 1'b0;
            end
        end
    end

    // Descriptor words; hardware updates follow the software write so they win a tie.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 5; i++) begin
                desc_q[i] <= `HSITD_WORD_RST;
            end
        end else if (ce) begin
            if (wr_fire && wr_idx <= `HSITD_IDX_UMASK) begin
                desc_q[wr_idx[2:0]] <= lane_merge(desc_q[wr_idx[2:0]], pwdata, pstrb);
            end
            if (hw_fatal || hw_stall || hw_retire) begin
                desc_q[0][`HSITD_DW0_VALID] <= 1'b0;
            end
            if (hw_stall) begin
                desc_q[3][`HSITD_DW3_HALT] <= 1'b1;
            end
            if (state_q == HSITD_ST_WAIT && xfer_done) begin
                desc_q[3][`HSITD_DW3_XCNT_LO +: 15] <= xcnt_next;
            end
            if (hw_finish) begin
                desc_q[4][7:0] <= umask_left;
            end
        end
    end

    assign ev[`HSITD_EV_DONE] = hw_retire;
    assign ev[`HSITD_EV_HALT] = hw_stall;
    assign ev[`HSITD_EV_ERR]  = hw_fatal;

    // Sticky event bits: a new event wins over a clear in the same cycle.
    for (genvar g = 0; g < `HSITD_NUM_EV; g++) begin : g_int
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                int_stat_q[g] <= 1'b0;
            end else if (ce) begin
                if (ev[g]) begin
                    int_stat_q[g] <= 1'b1;
                end else if (wr_fire && wr_idx == `HSITD_IDX_INT_CLR && pwdata[g]) begin
                    int_stat_q[g] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_en_q <= 3'h0;
            irq      <= 1'b0;
        end else if (ce) begin
            if (wr_fire && wr_idx == `HSITD_IDX_INT_EN) begin
                int_en_q <= pwdata[`HSITD_NUM_EV-1:0];
            end
            irq <= |(int_stat_q & int_en_q);
        end
    end

    // APB slave: the answer is prepared in the setup cycle, so access lasts one cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= `HSITD_WORD_RST;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            if (psel && !penable) begin
                pready  <= 1'b1;
                pslverr <= (rd_idx == `HSITD_IDX_NONE);
                prdata  <= `HSITD_WORD_RST;
                if (!pwrite) begin
                    if (rd_idx == `HSITD_IDX_DW3) begin
                        prdata <= {valid, desc_q[3][30:0]};
                    end else if (rd_idx <= `HSITD_IDX_UMASK) begin
                        prdata <= desc_q[rd_idx[2:0]];
                    end else if (rd_idx == `HSITD_IDX_STATE) begin
                        prdata <= {20'h0_0000, state_q == HSITD_ST_WAIT, bus_uframe,
                                   bus_frame_num, uframe_q};
                    end else if (rd_idx == `HSITD_IDX_INT_STAT) begin
                        prdata <= {29'h0000_0000, int_stat_q};
                    end else if (rd_idx == `HSITD_IDX_INT_EN) begin
                        prdata <= {29'h0000_0000, int_en_q};
                    end
                end
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_halt;
        (ce && state_q == HSITD_ST_WAIT && xfer_done && xfer_stall)
            |=> desc_q[3][`HSITD_DW3_HALT] && !valid && !xfer_req;
    endproperty
    a_halt: assert property (p_halt) else $error("stall did not halt");

    property p_count;
        (ce && state_q == HSITD_ST_WAIT && xfer_done && !xcnt_sum[15])
            |=> xcnt == $past(xcnt) + {4'h0, $past(xfer_bytes)};
    endproperty
    a_count: assert property (p_count) else $error("byte total wrong");

    property p_frame;
        $rose(xfer_req) |-> $past(frame_hit) && $past(umask[bus_uframe]);
    endproperty
    a_frame: assert property (p_frame) else $error("request outside its frame");

    property p_split;
        $rose(xfer_req) |-> xfer_split == $past(desc_q[1][`HSITD_DW1_SPLIT]);
    endproperty
    a_split: assert property (p_split) else $error("split select wrong");

    property p_token;
        $rose(xfer_req) |-> $past(cat_ok)
            && xfer_token == $past(desc_q[1][`HSITD_DW1_TOKEN_LO +: 2]);
    endproperty
    a_token: assert property (p_token) else $error("token or category wrong");

    property p_target;
        $rose(xfer_req) |-> xfer_dev_addr == $past(desc_q[1][`HSITD_DW1_DEV_LO +: 7])
            && xfer_endpoint == {$past(desc_q[1][2:0]), $past(desc_q[0][`HSITD_DW0_EP_LSB])};
    endproperty
    a_target: assert property (p_target) else $error("target address wrong");

    property p_mult;
        xfer_req |-> {1'b0, pkt_cnt_q} < {1'b0, mult_eff};
    endproperty
    a_mult: assert property (p_mult) else $error("too many packets");

    property p_len;
        xfer_req |-> xfer_max_len <= `HSITD_MAX_PKT_CEIL;
    endproperty
    a_len: assert property (p_len) else $error("packet length above ceiling");

    property p_retire;
        (ce && hw_retire) |=> !valid && int_stat_q[`HSITD_EV_DONE];
    endproperty
    a_retire: assert property (p_retire) else $error("valid not cleared");

    property p_umask;
        (ce && hw_finish) |=> !umask[uframe_q];
    endproperty
    a_umask: assert property (p_umask) else $error("microframe bit kept");
endmodule

// ==== rtl/hsitd_consts.svh ====
// Offsets, field positions, reset values and limits of the isochronous descriptor block.
`ifndef HSITD_CONSTS_SVH
`define HSITD_CONSTS_SVH

`define HSITD_OFF_DW0        12'h000
`define HSITD_OFF_DW1        12'h004
`define HSITD_OFF_DW2        12'h008
`define HSITD_OFF_DW3        12'h00C
`define HSITD_OFF_UMASK      12'h010
`define HSITD_OFF_STATE      12'h014
`define HSITD_OFF_INT_STAT   12'h018
`define HSITD_OFF_INT_CLR    12'h01C
`define HSITD_OFF_INT_EN     12'h020

`define HSITD_IDX_DW0        4'h0
`define HSITD_IDX_DW3        4'h3
`define HSITD_IDX_UMASK      4'h4
`define HSITD_IDX_STATE      4'h5
`define HSITD_IDX_INT_STAT   4'h6
`define HSITD_IDX_INT_CLR    4'h7
`define HSITD_IDX_INT_EN     4'h8
`define HSITD_IDX_NONE       4'hF

`define HSITD_DW0_VALID      0
`define HSITD_DW0_MAXPKT_LO  18
`define HSITD_DW0_MULT_LO    29
`define HSITD_DW0_EP_LSB     31
`define HSITD_DW1_EP_UPPER_LO 0
`define HSITD_DW1_DEV_LO     3
`define HSITD_DW1_TOKEN_LO   10
`define HSITD_DW1_EPCAT_LO   12
`define HSITD_DW1_SPLIT      14
`define HSITD_DW2_FRAME_LO   3
`define HSITD_DW2_BUF_LO     8
`define HSITD_DW3_XCNT_LO    0
`define HSITD_DW3_HALT       30
`define HSITD_DW3_ACTIVE     31

`define HSITD_EPCAT_ISO      2'h1
`define HSITD_TOKEN_OUT      2'h0
`define HSITD_TOKEN_IN       2'h1
`define HSITD_MAX_PKT_CEIL   11'h400
`define HSITD_XCNT_FULL      15'h7FFF
`define HSITD_WORD_RST       32'h0000_0000
`define HSITD_EV_DONE        0
`define HSITD_EV_HALT        1
`define HSITD_EV_ERR         2
`define HSITD_NUM_EV         3

`endif

// ==== rtl/hsitd_pkg.sv ====
// Types shared by the isochronous descriptor block.
package hsitd_pkg;
    typedef logic [31:0] hsitd_word_t;
    typedef enum logic {
        HSITD_ST_IDLE,
        HSITD_ST_WAIT
    } hsitd_state_t;
endpackage

// ==== rtl/hsitd_sync.sv ====
// Three-stage synchroniser that accepts a change once its last two stages agree.
`timescale 1ns/1ps
module hsitd_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic async_in,
    output logic      level_q
);
    logic [2:0] stage_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_q <= 3'h0;
        end else if (ce) begin
            stage_q <= {stage_q[1:0], async_in};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= 1'b0;
        end else if (ce && (stage_q[1] == stage_q[2])) begin
            level_q <= stage_q[2];
        end
    end
endmodule

// ==== verif/hsitd_usb_func_model.sv ====
// Behavioural USB function endpoint that answers the engine's packet requests.
`timescale 1ns/1ps
module hsitd_usb_func_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        xfer_req,
    input  wire logic [10:0] xfer_max_len,
    input  wire logic [7:0]  cfg_delay,
    input  wire logic        cfg_short,
    input  wire logic        cfg_stall,
    output logic             xfer_done,
    output logic [10:0]      xfer_bytes,
    output logic             xfer_stall,
    output logic [7:0]       pkt_cnt
);
    logic [7:0]  wait_q;
    logic [10:0] len;

    // A packet carries the largest packet length, or one byte less when cfg_short is set (wrapping to 2047 when the length is zero).
    assign len = cfg_short ? xfer_max_len - 11'h001 : xfer_max_len;
    // Outside the done cycle the lines show garbage so nothing stale passes as valid.
    assign xfer_bytes = xfer_done ? len : ~len;
    assign xfer_stall = xfer_done ? cfg_stall : ~cfg_stall;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q    <= 8'h00;
            xfer_done <= 1'b0;
            pkt_cnt   <= 8'h00;
        end else begin
            xfer_done <= 1'b0;
            if (!xfer_req || xfer_done) begin
                wait_q <= cfg_delay;
            end else if (wait_q == 8'h00) begin
                xfer_done <= 1'b1;
                pkt_cnt   <= pkt_cnt + 8'h01;
            end else begin
                wait_q <= wait_q - 8'h01;
            end
        end
    end
endmodule

// ==== verif/hsitd_top_tb.sv ====
// Self-checking bench for the isochronous descriptor engine.
`timescale 1ns/1ps
`include "hsitd_consts.svh"
module hsitd_top_tb
    import hsitd_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        ce = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    hsitd_word_t pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        sof_pin = 1'b0;
    logic [4:0]  bus_frame_num = 5'h00;
    logic [2:0]  bus_uframe = 3'h0;
    logic        xfer_req;
    logic [1:0]  xfer_token;
    logic [6:0]  xfer_dev_addr;
    logic [3:0]  xfer_endpoint;
    logic        xfer_split;
    logic [10:0] xfer_max_len;
    logic [15:0] xfer_buf_addr;
    logic        xfer_done;
    logic [10:0] xfer_bytes;
    logic        xfer_stall;
    logic [7:0]  cfg_delay = 8'h03;
    logic        cfg_short = 1'b0;
    logic        cfg_stall = 1'b0;
    logic [7:0]  pkt_cnt;
    logic [7:0]  p0;
    logic        req_seen = 1'b0;
    logic [40:0] cap = 41'h0;
    hsitd_word_t rd_v;
    hsitd_word_t d0;
    hsitd_word_t d1;
    hsitd_word_t d2;
    hsitd_word_t bufa;
    logic        err_v;
    int          n_fail = 0;
    int          checks = 0;
    int          cyc = 0;

    hsitd_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .sof_pin(sof_pin),
        .bus_frame_num(bus_frame_num), .bus_uframe(bus_uframe), .xfer_req(xfer_req),
        .xfer_token(xfer_token), .xfer_dev_addr(xfer_dev_addr), .xfer_endpoint(xfer_endpoint),
        .xfer_split(xfer_split), .xfer_max_len(xfer_max_len), .xfer_buf_addr(xfer_buf_addr),
        .xfer_done(xfer_done), .xfer_bytes(xfer_bytes), .xfer_stall(xfer_stall));

    hsitd_usb_func_model i_func (.pclk(pclk), .presetn(presetn), .xfer_req(xfer_req),
        .xfer_max_len(xfer_max_len), .cfg_delay(cfg_delay), .cfg_short(cfg_short),
        .cfg_stall(cfg_stall), .xfer_done(xfer_done), .xfer_bytes(xfer_bytes),
        .xfer_stall(xfer_stall), .pkt_cnt(pkt_cnt));

    always #2.5 pclk = ~pclk;

    // Latches the request fields on the first cycle of each transfer.
    always @(posedge pclk) begin
        if (xfer_req === 1'b1 && !req_seen) begin
            req_seen <= 1'b1;
            cap <= {xfer_token, xfer_dev_addr, xfer_endpoint, xfer_split, xfer_max_len,
                    xfer_buf_addr};
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input hsitd_word_t d);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input hsitd_word_t d);
        apb(a, 1'b1, d);
    endtask

    task automatic rd_chk(input logic [11:0] a, input hsitd_word_t m, input hsitd_word_t e);
        apb(a, 1'b0, 32'h0000_0000);
        chk(rd_v & m, e);
    endtask

    task automatic irq_chk(input logic e);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(irq, e);
        @(posedge pclk);
    endtask

    function automatic hsitd_word_t fld(input hsitd_word_t v, input int lo);
        return v << lo;
    endfunction

    task automatic sof_go(input logic [4:0] f, input logic [2:0] u);
        int n;
        req_seen <= 1'b0;
        bus_frame_num <= f;
        bus_uframe <= u;
        sof_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        sof_pin <= 1'b0;
        for (n = 0; n < 30 && !req_seen; n++) @(posedge pclk);
        for (n = 0; n < 400 && xfer_req !== 1'b0; n++) @(posedge pclk);
        repeat (3) @(posedge pclk);
    endtask

    task automatic iso_case(input logic [7:0] m, input logic [4:0] f, input logic [2:0] u);
        wr(`HSITD_OFF_DW3, `HSITD_WORD_RST);
        wr(`HSITD_OFF_DW1, d1);
        wr(`HSITD_OFF_DW2, d2);
        wr(`HSITD_OFF_UMASK, {24'h00_0000, m});
        wr(`HSITD_OFF_DW0, d0);
        sof_go(f, u);
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 9; i++) begin
            if (i != 7) rd_chk(12'(i * 4), 32'hFFFF_FFFF, `HSITD_WORD_RST);
        end
        apb(12'h100, 1'b0, 32'h0000_0000);
        chk({err_v, rd_v}, {1'b1, 32'h0000_0000});
        wr(`HSITD_OFF_INT_EN, 32'h0000_0007);
        // OUT, split, even length, junk in the ignored low frame bits.
        bufa = (32'h0000_9DA0 - 32'h0000_0400) >> 3;
        d0 = fld(32'h0000_0001, `HSITD_DW0_VALID) | fld(32'h0000_0064, `HSITD_DW0_MAXPKT_LO)
           | fld(32'h0000_0001, `HSITD_DW0_MULT_LO) | fld(32'h0000_0001, `HSITD_DW0_EP_LSB);
        d1 = fld(32'h0000_0005, `HSITD_DW1_EP_UPPER_LO) | fld(32'h0000_0055, `HSITD_DW1_DEV_LO)
           | fld(`HSITD_TOKEN_OUT, `HSITD_DW1_TOKEN_LO) | fld(`HSITD_EPCAT_ISO, `HSITD_DW1_EPCAT_LO)
           | fld(32'h0000_0001, `HSITD_DW1_SPLIT);
        d2 = fld(32'h0000_0009, `HSITD_DW2_FRAME_LO) | 32'h0000_0007 | fld(bufa, `HSITD_DW2_BUF_LO);
        iso_case(8'h04, 5'h09, 3'h3);
        chk(req_seen, 1'b0);
        rd_chk(`HSITD_OFF_DW1, 32'hFFFF_FFFF, d1);
        sof_go(5'h08, 3'h2);
        chk(req_seen, 1'b0);
        sof_go(5'h09, 3'h2);
        chk(req_seen, 1'b1);
        chk(cap, {`HSITD_TOKEN_OUT, 7'h55, 4'hB, 1'b1, 11'h064, bufa[15:0]});
        rd_chk(`HSITD_OFF_DW3, 32'h0000_7FFF, 32'h0000_0064);
        rd_chk(`HSITD_OFF_UMASK, 32'h0000_00FF, 32'h0000_0000);
        rd_chk(`HSITD_OFF_DW0, 32'h0000_0001, 32'h0000_0000);
        rd_chk(`HSITD_OFF_INT_STAT, 32'h0000_0001, 32'h0000_0001);
        irq_chk(1'b1);
        wr(`HSITD_OFF_INT_CLR, 32'h0000_0007);
        irq_chk(1'b0);
        // IN, three full packets, oversize length clipped.
        d0 = fld(32'h0000_0001, `HSITD_DW0_VALID) | fld(32'h0000_07FF, `HSITD_DW0_MAXPKT_LO)
           | fld(32'h0000_0003, `HSITD_DW0_MULT_LO);
        d1 = fld(32'h0000_0001, `HSITD_DW1_DEV_LO) | fld(`HSITD_TOKEN_IN, `HSITD_DW1_TOKEN_LO)
           | fld(`HSITD_EPCAT_ISO, `HSITD_DW1_EPCAT_LO);
        d2 = fld(32'h0000_0003, `HSITD_DW2_FRAME_LO) | fld(32'h0000_0010, `HSITD_DW2_BUF_LO);
        p0 = pkt_cnt;
        iso_case(8'h01, 5'h03, 3'h0);
        chk(pkt_cnt - p0, 8'h03);
        chk(cap, {`HSITD_TOKEN_IN, 7'h01, 4'h0, 1'b0, `HSITD_MAX_PKT_CEIL, 16'h0010});
        chk(xfer_buf_addr, 16'h0110);
        rd_chk(`HSITD_OFF_DW3, 32'h0000_7FFF, 32'h0000_0C00);
        // A short packet ends the microframe early.
        d0 = fld(32'h0000_0001, `HSITD_DW0_VALID) | fld(32'h0000_00C9, `HSITD_DW0_MAXPKT_LO)
           | fld(32'h0000_0003, `HSITD_DW0_MULT_LO);
        cfg_short <= 1'b1;
        p0 = pkt_cnt;
        iso_case(8'h01, 5'h03, 3'h0);
        chk(pkt_cnt - p0, 8'h01);
        rd_chk(`HSITD_OFF_DW3, 32'h0000_7FFF, 32'h0000_00C8);
        // Stall: halt set, valid dropped, interrupt masked then enabled.
        cfg_short <= 1'b0;
        cfg_stall <= 1'b1;
        wr(`HSITD_OFF_INT_CLR, 32'h0000_0007);
        wr(`HSITD_OFF_INT_EN, 32'h0000_0004);
        iso_case(8'h01, 5'h03, 3'h0);
        rd_chk(`HSITD_OFF_DW3, 32'hC000_0000, 32'h4000_0000);
        rd_chk(`HSITD_OFF_DW0, 32'h0000_0001, 32'h0000_0000);
        rd_chk(`HSITD_OFF_INT_STAT, 32'h0000_0002, 32'h0000_0002);
        irq_chk(1'b0);
        wr(`HSITD_OFF_INT_EN, 32'h0000_0002);
        irq_chk(1'b1);
        wr(`HSITD_OFF_INT_CLR, 32'h0000_0007);
        irq_chk(1'b0);
        // A non-isochronous category is refused.
        cfg_stall <= 1'b0;
        d1 = fld(32'h0000_0002, `HSITD_DW1_EPCAT_LO);
        iso_case(8'h01, 5'h03, 3'h0);
        chk(req_seen, 1'b0);
        rd_chk(`HSITD_OFF_INT_STAT, 32'h0000_0004, 32'h0000_0004);
        rd_chk(`HSITD_OFF_DW0, 32'h0000_0001, 32'h0000_0000);
        tally_and_finish();
    end
endmodule
